// ===== include/ssp_defines.vh
/*
  constants of the synchronous serial port: register addresses, control
  field positions, reset values, interrupt status layout.
  assumes a 16-bit register port with byte addresses as printed.
*/
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

// register addresses
`define SSP_ADDR_CTRL 16'hffb2
`define SSP_ADDR_TXBUF 16'hffb4
`define SSP_ADDR_RXBUF 16'hffb6
`define SSP_ADDR_BAUD 16'hffb8
`define SSP_ADDR_IRQ_STAT 16'hffba
`define SSP_ADDR_IRQ_CLR 16'hffbc
`define SSP_ADDR_IRQ_EN 16'hffbe

// control field positions, programming view
`define SSP_WIDTH_LSB 0
`define SSP_WIDTH_MSB 3
`define SSP_B_ORDER 4
`define SSP_B_PHASE 5
`define SSP_B_POL 6
`define SSP_B_TXCHK 8
`define SSP_B_RXCHK 9
`define SSP_B_PHCHK 10
`define SSP_B_BDCHK 11
`define SSP_B_AREN 12
`define SSP_B_MASTER 14
`define SSP_B_ENABLE 15

// status view flags (share bits 8..10 with the check enables)
`define SSP_B_TXERR 8
`define SSP_B_RXERR 9
`define SSP_B_PHERR 10
`define SSP_B_BUSY 12

// reset values
`define SSP_CTRL_RST 16'h0000
`define SSP_WIDTH_RST 4'h0
`define SSP_BAUD_RST 16'h0000
`define SSP_WORD_RST 16'h0000

// interrupt status layout
`define SSP_IRQ_W 4
`define SSP_IRQ_TXBUF 0
`define SSP_IRQ_DONE 1
`define SSP_IRQ_RX 2
`define SSP_IRQ_ERR 3

`endif

// ===== rtl/ssp_baud.v
/*
  baud generator of the synchronous serial port: 16-bit reload counter,
  one tick every reload+1 clocks while running.
  assumes the reload value is stable while the port is enabled.
*/
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_baud #(
  parameter W = 16 // reload width
) (
  input wire ref_clk,
  input wire nrst,
  input wire run,
  input wire [W-1:0] reload,
  output reg tick
);
  reg [W-1:0] cnt; // down counter

  // count down, tick and reload at zero; a stop reloads so
  // the first half period after a start is always whole
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= `SSP_BAUD_RST;
      tick <= 1'b0;
    end else if (!run) begin
      cnt <= reload;
      tick <= 1'b0;
    end else if (cnt == {W{1'b0}}) begin
      cnt <= reload;
      tick <= 1'b1;
    end else begin
      cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule // ssp_baud

// ===== rtl/ssp_shift.v
/*
  shift register pair of the synchronous serial port: transmit word out,
  receive word in, width and bit order set by the caller.
  assumes load, shift and latch strobes are one clock long.
*/
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_shift #(
  parameter W = 16 // widest word
) (
  input wire ref_clk,
  input wire nrst,
  input wire load,
  input wire load_shift,
  input wire [W-1:0] load_data,
  input wire shift,
  input wire latch,
  input wire din,
  input wire msb_first,
  input wire [3:0] width_m1,
  output reg dout,
  output wire [W-1:0] rx_word
);
  reg [W-1:0] tx; // outgoing bits
  reg [W-1:0] rx; // incoming bits
  wire [W-1:0] src; // word the next shift works on
  wire head; // bit to present next
  wire [W-1:0] mask; // ones in the word's width

  assign src = load ? load_data : tx;
  assign head = msb_first ? src[width_m1] : src[0];
  assign mask = ~({W{1'b1}} << ({1'b0, width_m1} + 5'd1));
  // lsb-first words enter at the top and are aligned down here
  assign rx_word = msb_first ? (rx & mask) : (rx >> (4'd15 - width_m1));

  // transmit side: a shift presents the head bit on the line
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx <= `SSP_WORD_RST;
      dout <= 1'b0;
    end else if ((load && load_shift) || (!load && shift)) begin
      dout <= head;
      tx <= msb_first ? (src << 1) : (src >> 1);
    end else if (load) begin
      tx <= load_data;
    end
  end

  // receive side: a latch takes one bit in
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx <= `SSP_WORD_RST;
    end else if (latch) begin
      rx <= msb_first ? {rx[W-2:0], din} : {din, rx[W-1:1]};
    end
  end
endmodule // ssp_shift

// ===== rtl/ssp_core.v
/*
  synchronous serial port core: control and buffer registers, master
  clock generation, slave clock sensing, word sequencing, interrupts.
  assumes a plain register port with read data one clock after the
  strobe, and pins that arrive asynchronously to ref_clk.
*/
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_core #(
  parameter W = 16 // word and register width
) (
  input wire ref_clk,
  input wire nrst,
  input wire [15:0] reg_addr,
  input wire [W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [W-1:0] reg_rdata,
  input wire shift_clk_in,
  output wire shift_clk_out,
  output wire shift_clk_oe,
  input wire master_out_slave_in_line_in,
  output wire master_out_slave_in_line_out,
  output wire master_out_slave_in_line_oe,
  input wire master_in_slave_out_line_in,
  output wire master_in_slave_out_line_out,
  output wire master_in_slave_out_line_oe,
  output wire irq
);
  // control bits
  reg [3:0] width_m1; // word width minus one
  reg bit_order_select; // 1: msb first
  reg clock_phase_select; // edge pairing
  reg clock_polarity_select; // idle level
  reg tx_error_check_enable;
  reg rx_error_check_enable;
  reg phase_error_check_enable;
  reg baud_error_check_enable; // stored only
  reg auto_restart_enable; // stored only
  reg master_select; // 1: this end drives the clock
  reg unit_enable_bit;

  // status flags
  reg tx_err;
  reg rx_err;
  reg ph_err;

  // buffers and sequencing
  reg [W-1:0] tx_buf; // word waiting to be sent
  reg tx_full; // tx_buf holds an unsent word
  reg [W-1:0] rx_buf; // last complete word received
  reg rx_full; // rx_buf not yet read
  reg [15:0] baud_reload;
  reg busy; // a word is on the wire
  reg loaded; // shift register holds an unsent word
  reg [3:0] bit_cnt; // trailing edges seen this word
  reg clk_q; // master clock level
  reg done_d; // word finished one clock ago

  // interrupt registers
  reg [`SSP_IRQ_W-1:0] irq_stat;
  reg [`SSP_IRQ_W-1:0] irq_en;

  // pin synchronisers: stage one is read only by stage two
  reg [2:0] sync1;
  reg [2:0] sync2;
  reg [2:0] sync3; // one clock older, for edges and phase checks

  wire acc_ctrl; // strobes aimed at each address
  wire wr_ctrl;
  wire wr_txbuf;
  wire rd_rxbuf;
  wire wr_baud;
  wire wr_clr;
  wire wr_ien;
  wire tick; // baud half period elapsed
  wire sclk_s; // synced clock pin
  wire din_s; // synced receive line
  wire din_d; // receive line one clock older
  wire lead_ev; // leading clock edge
  wire trail_ev; // trailing clock edge
  wire shift_ev;
  wire latch_ev;
  wire word_done;
  wire load_now;
  wire start;
  wire tx_err_ev;
  wire rx_err_ev;
  wire ph_err_ev;
  wire [W-1:0] rx_word;
  wire dout;
  wire [W-1:0] ctrl_view;
  wire [`SSP_IRQ_W-1:0] irq_ev;
  reg [W-1:0] next_rdata;

  assign acc_ctrl = (reg_addr == `SSP_ADDR_CTRL);
  assign wr_ctrl = reg_wr && acc_ctrl;
  assign wr_txbuf = reg_wr && (reg_addr == `SSP_ADDR_TXBUF);
  assign rd_rxbuf = reg_rd && (reg_addr == `SSP_ADDR_RXBUF);
  assign wr_baud = reg_wr && (reg_addr == `SSP_ADDR_BAUD);
  assign wr_clr = reg_wr && (reg_addr == `SSP_ADDR_IRQ_CLR);
  assign wr_ien = reg_wr && (reg_addr == `SSP_ADDR_IRQ_EN);

  // bring the three pins into the clock domain
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
    end else begin
      sync1 <= {master_in_slave_out_line_in, master_out_slave_in_line_in, shift_clk_in};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign sclk_s = sync2[0];
  // master samples the slave's line, slave samples the master's
  assign din_s = master_select ? sync2[2] : sync2[1];
  assign din_d = master_select ? sync3[2] : sync3[1];

  // master edges come from its own clock, slave edges from the pin;
  // polarity names which transition counts as leading
  assign lead_ev = master_select ? (tick && busy && (clk_q == clock_polarity_select))
    : (unit_enable_bit && (sclk_s != sync3[0]) && (sync3[0] == clock_polarity_select));
  assign trail_ev = master_select ? (tick && busy && (clk_q != clock_polarity_select))
    : (unit_enable_bit && busy && (sclk_s != sync3[0]) && (sclk_s == clock_polarity_select));
  // phase 0 shifts on leading, latches on trailing; phase 1 the reverse
  assign shift_ev = clock_phase_select ? trail_ev : lead_ev;
  assign latch_ev = clock_phase_select ? lead_ev : trail_ev;
  assign word_done = trail_ev && (bit_cnt == width_m1);

  // refill the shift register from the buffer when idle-empty or at word end
  assign load_now = unit_enable_bit && tx_full && ((!busy && !loaded) || word_done);
  assign start = unit_enable_bit && master_select && !busy && loaded;

  // error events, each gated by its check enable
  assign tx_err_ev = tx_error_check_enable && !master_select && lead_ev && !busy && !loaded;
  assign rx_err_ev = rx_error_check_enable && done_d && rx_full && !rd_rxbuf;
  assign ph_err_ev = phase_error_check_enable && !master_select && latch_ev && (din_s != din_d);

  ssp_baud #(
    .W(16)
  ) u_baud (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(unit_enable_bit && master_select && busy),
    .reload(baud_reload),
    .tick(tick)
  );

  ssp_shift #(
    .W(W)
  ) u_shift (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .load(load_now),
    .load_shift(clock_phase_select),
    .load_data(tx_buf),
    .shift(shift_ev),
    .latch(latch_ev),
    .din(din_s),
    .msb_first(bit_order_select),
    .width_m1(width_m1),
    .dout(dout),
    .rx_word(rx_word)
  );

  // control register: the write view depends on the enable bit
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      width_m1 <= `SSP_WIDTH_RST;
      bit_order_select <= 1'b0;
      clock_phase_select <= 1'b0;
      clock_polarity_select <= 1'b0;
      tx_error_check_enable <= 1'b0;
      rx_error_check_enable <= 1'b0;
      phase_error_check_enable <= 1'b0;
      baud_error_check_enable <= 1'b0;
      auto_restart_enable <= 1'b0;
      master_select <= 1'b0;
      unit_enable_bit <= 1'b0;
    end else if (wr_ctrl && !unit_enable_bit) begin
      // programming view: every setup bit is reachable
      width_m1 <= reg_wdata[`SSP_WIDTH_MSB:`SSP_WIDTH_LSB];
      bit_order_select <= reg_wdata[`SSP_B_ORDER];
      clock_phase_select <= reg_wdata[`SSP_B_PHASE];
      clock_polarity_select <= reg_wdata[`SSP_B_POL];
      tx_error_check_enable <= reg_wdata[`SSP_B_TXCHK];
      rx_error_check_enable <= reg_wdata[`SSP_B_RXCHK];
      phase_error_check_enable <= reg_wdata[`SSP_B_PHCHK];
      baud_error_check_enable <= reg_wdata[`SSP_B_BDCHK];
      auto_restart_enable <= reg_wdata[`SSP_B_AREN];
      master_select <= reg_wdata[`SSP_B_MASTER];
      unit_enable_bit <= reg_wdata[`SSP_B_ENABLE];
    end else if (wr_ctrl) begin
      // operating view: setup stays frozen, only role and enable move
      master_select <= reg_wdata[`SSP_B_MASTER];
      unit_enable_bit <= reg_wdata[`SSP_B_ENABLE];
    end
  end

  // error flags: software clears by writing zero in the operating view,
  // a new error in the same clock wins
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_err <= 1'b0;
      rx_err <= 1'b0;
      ph_err <= 1'b0;
    end else begin
      tx_err <= tx_err_ev || (tx_err && !(wr_ctrl && unit_enable_bit && !reg_wdata[`SSP_B_TXERR]));
      rx_err <= rx_err_ev || (rx_err && !(wr_ctrl && unit_enable_bit && !reg_wdata[`SSP_B_RXERR]));
      ph_err <= ph_err_ev || (ph_err && !(wr_ctrl && unit_enable_bit && !reg_wdata[`SSP_B_PHERR]));
    end
  end

  // buffers and baud reload
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_buf <= `SSP_WORD_RST;
      tx_full <= 1'b0;
      rx_buf <= `SSP_WORD_RST;
      rx_full <= 1'b0;
      baud_reload <= `SSP_BAUD_RST;
    end else begin
      if (wr_txbuf) begin
        tx_buf <= reg_wdata; // a write over a full buffer replaces it
      end
      // a write in the moving clock keeps the buffer full
      tx_full <= wr_txbuf || (tx_full && !load_now);
      if (done_d) begin
        rx_buf <= rx_word;
      end
      // an arriving word beats a read in the same clock
      rx_full <= done_d || (rx_full && !rd_rxbuf);
      if (wr_baud) begin
        baud_reload <= reg_wdata;
      end
    end
  end

  // word sequencing for both roles
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      loaded <= 1'b0;
      bit_cnt <= 4'h0;
      done_d <= 1'b0;
    end else if (!unit_enable_bit) begin
      // disabling abandons any word on the wire
      busy <= 1'b0;
      loaded <= 1'b0;
      bit_cnt <= 4'h0;
      done_d <= 1'b0;
    end else begin
      done_d <= word_done;
      if (word_done) begin
        bit_cnt <= 4'h0;
        loaded <= load_now;
        // master runs on while data waits; slave rearms for the next edge
        busy <= master_select && load_now;
      end else begin
        if (trail_ev) begin
          bit_cnt <= bit_cnt + 4'h1;
        end
        if (load_now) begin
          loaded <= 1'b1;
        end
        if (start || (!master_select && lead_ev && !busy)) begin
          busy <= 1'b1;
        end
      end
    end
  end

  // master clock: rests at the idle level, toggles on each baud tick;
  // the first edge comes a half period after start, giving data setup
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clk_q <= 1'b0;
    end else if (!busy) begin
      clk_q <= clock_polarity_select;
    end else if (tick) begin
      clk_q <= ~clk_q;
    end
  end

  // pin drivers: clock and data out follow the role
  assign shift_clk_out = clk_q;
  assign shift_clk_oe = unit_enable_bit && master_select;
  assign master_out_slave_in_line_out = dout;
  assign master_out_slave_in_line_oe = unit_enable_bit && master_select;
  assign master_in_slave_out_line_out = dout;
  assign master_in_slave_out_line_oe = unit_enable_bit && !master_select;

  // same address, two faces
  assign ctrl_view = unit_enable_bit ?
    (({{(W-4){1'b0}}, bit_cnt} << `SSP_WIDTH_LSB)
    | ({{(W-1){1'b0}}, tx_err} << `SSP_B_TXERR)
    | ({{(W-1){1'b0}}, rx_err} << `SSP_B_RXERR)
    | ({{(W-1){1'b0}}, ph_err} << `SSP_B_PHERR)
    | ({{(W-1){1'b0}}, busy} << `SSP_B_BUSY)
    | ({{(W-1){1'b0}}, master_select} << `SSP_B_MASTER)
    | ({{(W-1){1'b0}}, 1'b1} << `SSP_B_ENABLE)) :
    (({{(W-4){1'b0}}, width_m1} << `SSP_WIDTH_LSB)
    | ({{(W-1){1'b0}}, bit_order_select} << `SSP_B_ORDER)
    | ({{(W-1){1'b0}}, clock_phase_select} << `SSP_B_PHASE)
    | ({{(W-1){1'b0}}, clock_polarity_select} << `SSP_B_POL)
    | ({{(W-1){1'b0}}, tx_error_check_enable} << `SSP_B_TXCHK)
    | ({{(W-1){1'b0}}, rx_error_check_enable} << `SSP_B_RXCHK)
    | ({{(W-1){1'b0}}, phase_error_check_enable} << `SSP_B_PHCHK)
    | ({{(W-1){1'b0}}, baud_error_check_enable} << `SSP_B_BDCHK)
    | ({{(W-1){1'b0}}, auto_restart_enable} << `SSP_B_AREN)
    | ({{(W-1){1'b0}}, master_select} << `SSP_B_MASTER));

  // read mux; write-only and unmapped addresses read as zero
  always @* begin
    next_rdata = {W{1'b0}};
    if (reg_rd) begin
      case (reg_addr)
        `SSP_ADDR_CTRL: next_rdata = ctrl_view;
        `SSP_ADDR_TXBUF: next_rdata = tx_buf;
        `SSP_ADDR_RXBUF: next_rdata = rx_buf;
        `SSP_ADDR_BAUD: next_rdata = baud_reload;
        `SSP_ADDR_IRQ_STAT: next_rdata = {{(W-`SSP_IRQ_W){1'b0}}, irq_stat};
        `SSP_ADDR_IRQ_EN: next_rdata = {{(W-`SSP_IRQ_W){1'b0}}, irq_en};
        default: next_rdata = {W{1'b0}};
      endcase
    end
  end

  // read data stands for exactly the clock after the strobe
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= {W{1'b0}};
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // interrupt events: buffer moved, word done, word received, error
  assign irq_ev[`SSP_IRQ_TXBUF] = load_now;
  assign irq_ev[`SSP_IRQ_DONE] = done_d;
  assign irq_ev[`SSP_IRQ_RX] = done_d;
  assign irq_ev[`SSP_IRQ_ERR] = tx_err_ev || rx_err_ev || ph_err_ev;

  // sticky status, clear by writing ones, set beats clear
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= {`SSP_IRQ_W{1'b0}};
      irq_en <= {`SSP_IRQ_W{1'b0}};
    end else begin
      irq_stat <= irq_ev | (irq_stat & ~(wr_clr ? reg_wdata[`SSP_IRQ_W-1:0] : {`SSP_IRQ_W{1'b0}}));
      if (wr_ien) begin
        irq_en <= reg_wdata[`SSP_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat & irq_en);
endmodule // ssp_core

// ===== tb/ssp_core_assertions.sv
/*
  checker of the serial port core: register views, pin enables, clock timing.
  assumes it is bound to ssp_core and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_core_assertions #(
  parameter W = 16 // register width
) (
  input wire ref_clk,
  input wire nrst,
  input wire [15:0] reg_addr,
  input wire [W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [W-1:0] reg_rdata,
  input wire shift_clk_out,
  input wire shift_clk_oe,
  input wire master_out_slave_in_line_oe,
  input wire master_in_slave_out_line_oe,
  input wire irq
);
  reg en_h; // enable as last written
  reg mst_h; // master as last written
  reg pol; // idle clock level
  reg [15:0] cfg_h; // expected programming view
  reg [15:0] rld; // baud reload
  reg prev; // clock pin one cycle ago
  reg lead; // last clock change left the idle level
  reg [15:0] cnt; // cycles since the last clock change
  wire ctl_wr = reg_wr && reg_addr == `SSP_ADDR_CTRL;
  // shadow the bus so the checks never look inside the core
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      en_h <= 1'b0;
      mst_h <= 1'b0;
      pol <= 1'b0;
      cfg_h <= 16'h0000;
      rld <= 16'h0000;
      prev <= 1'b0;
      lead <= 1'b0;
      cnt <= 16'h0000;
    end else begin
      if (ctl_wr) begin
        en_h <= reg_wdata[15];
        mst_h <= reg_wdata[14];
      end
      // setup bits are frozen while enabled
      if (ctl_wr && !en_h) begin
        pol <= reg_wdata[6];
        cfg_h <= reg_wdata & 16'h5f7f;
      end
      if (reg_wr && reg_addr == `SSP_ADDR_BAUD) begin
        rld <= reg_wdata;
      end
      prev <= shift_clk_out;
      // saturate so a long rest never wraps into a false match
      if (shift_clk_out != prev) begin
        cnt <= 16'h0000;
        lead <= shift_clk_oe && (shift_clk_out != pol);
      end else if (cnt != 16'hffff) begin
        cnt <= cnt + 16'h0001;
      end
    end
  end
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_ctrl_rd;
    reg_rd && reg_addr == `SSP_ADDR_CTRL;
  endsequence
  sequence s_trail;
    shift_clk_oe && lead && shift_clk_out != prev && shift_clk_out == pol;
  endsequence
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_prog_view: assert property (s_ctrl_rd ##0 !en_h |=> reg_rdata == cfg_h)
    else $error("control read while disabled wrong");
  a_run_view: assert property (s_ctrl_rd ##0 en_h |=> reg_rdata[15] &&
    reg_rdata[14] == mst_h && reg_rdata[7:4] == 4'h0 && !reg_rdata[13] && !reg_rdata[11])
    else $error("control read while enabled wrong");
  a_clk_drive: assert property (shift_clk_oe == (en_h && mst_h))
    else $error("clock pin enable wrong");
  a_line_drive: assert property (master_out_slave_in_line_oe == shift_clk_oe &&
    master_in_slave_out_line_oe == (en_h && !mst_h))
    else $error("data pin enables wrong");
  a_clk_rest: assert property ($rose(shift_clk_oe) |=> shift_clk_out == pol)
    else $error("clock not at idle level");
  a_half_period: assert property (s_trail |-> cnt == rld)
    else $error("clock half period wrong");
  a_irq_clear: assert property (reg_wr && reg_addr == `SSP_ADDR_IRQ_CLR &&
    reg_wdata[3:0] == 4'hf && !en_h |=> !irq)
    else $error("interrupt not cleared");
endmodule // ssp_core_assertions

bind ssp_core ssp_core_assertions #(.W(W)) ssp_core_assertions_i (
  .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .shift_clk_out(shift_clk_out), .shift_clk_oe(shift_clk_oe),
  .master_out_slave_in_line_oe(master_out_slave_in_line_oe),
  .master_in_slave_out_line_oe(master_in_slave_out_line_oe), .irq(irq));

// ===== tb/ssp_chain_model.sv
/*
  partner on the serial lines: a chain of bits clocked by the shift clock.
  assumes mode inputs change only while clr holds the chain.
*/
`timescale 1ns/1ps
module ssp_chain_model (
  input wire sclk,
  input wire mosi,
  input wire pol,
  input wire pha,
  input wire [4:0] nbits,
  input wire clr,
  output wire miso,
  output reg [15:0] got,
  output reg [7:0] words
);
  reg [4:0] bits; // bits taken in this word
  initial words = 8'h00;
  // chain end drives the return line after a clock-to-out delay
  assign #2 miso = got[nbits-1];
  // latch edge is rising when polarity and phase differ, so the chain
  // never samples on the edge at which the core moves its data
  always @(posedge sclk or negedge sclk or posedge clr) begin
    if (clr) begin
      got <= 16'h0000;
      bits <= 5'd0;
    end else if (sclk == (pol != pha)) begin
      got <= {got[14:0], mosi};
      // a full word hands the old content back, in sent order
      if (bits + 5'd1 == nbits) begin
        bits <= 5'd0;
        words <= words + 8'h01;
      end else begin
        bits <= bits + 5'd1;
      end
    end
  end
endmodule // ssp_chain_model

// ===== tb/tb_ssp_core.sv
/*
  self-checking bench of the serial port core as master against a bit chain, then as slave for a transmit error.
  assumes the core, the chain model and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "ssp_defines.vh"
module tb_ssp_core;
  reg ref_clk = 1'b0; // 125 MHz
  reg nrst = 1'b0; // held low at start
  reg [15:0] reg_addr = 16'h0000;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg pol_t = 1'b0; // idle level the clock pin rests at
  reg pha_t = 1'b0;
  reg clr = 1'b0; // raised to clear the chain while modes change
  reg [4:0] nbits = 5'd8;
  reg [15:0] msk;
  wire [15:0] reg_rdata;
  wire sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq, m_miso;
  wire [15:0] m_got;
  wire [7:0] m_words;
  // undriven pins fall back to their pulls
  wire sclk_w = sclk_oe ? sclk_o : pol_t;
  wire mosi_w = mosi_oe ? mosi_o : 1'b1;
  wire miso_w = miso_oe ? miso_o : m_miso;
  integer miscompares = 0;
  integer tests_run = 0;
  integer c, i, k, tmp;
  reg [16:0] rq[$]; // pending reads: check flag and value
  reg [15:0] cq[$]; // words the chain should capture
  reg [16:0] e;
  reg [7:0] seen = 8'h00;
  reg rd_d = 1'b0;
  reg [15:0] cf;
  reg [15:0] ws[0:2];
  reg [15:0] cfgs[0:3];
  reg [15:0] rlds[0:3];
  always #4 ref_clk = ~ref_clk;
  ssp_core ssp_core_i (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shift_clk_in(sclk_w),
    .shift_clk_out(sclk_o), .shift_clk_oe(sclk_oe),
    .master_out_slave_in_line_in(mosi_w), .master_out_slave_in_line_out(mosi_o),
    .master_out_slave_in_line_oe(mosi_oe), .master_in_slave_out_line_in(miso_w),
    .master_in_slave_out_line_out(miso_o), .master_in_slave_out_line_oe(miso_oe),
    .irq(irq));
  ssp_chain_model ssp_chain_model_i (
    .sclk(sclk_w), .mosi(mosi_w), .pol(pol_t), .pha(pha_t), .nbits(nbits),
    .clr(clr), .miso(m_miso), .got(m_got), .words(m_words));
  task end_of_test;
    begin
      if (miscompares == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task cmp(input [8*10:1] nm, input [15:0] ex, input [15:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== ex) begin
        miscompares = miscompares + 1;
        $display("BAD %0s expected %h seen %h", nm, ex, g);
      end
    end
  endtask
  // one-cycle bus strobes, changed just after the edge
  task wr(input [15:0] a, input [15:0] d);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [15:0] ex, input chk);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      rq.push_back({chk, ex});
      @(posedge ref_clk);
      reg_rd <= 1'b0;
    end
  endtask
  // bit sequence the chain holds after one word
  function [15:0] bits_of(input [15:0] w, input [4:0] n, input m);
    integer j;
    begin
      bits_of = 16'h0000;
      for (j = 0; j < 16; j = j + 1)
        if (j < n) bits_of[j] = m ? w[j] : w[n-1-j];
    end
  endfunction
  // waits settle past the edge so combinational flags are final
  task settle;
    begin
      @(posedge ref_clk);
      #1;
      k = k + 1;
    end
  endtask
  // result watcher: read data one cycle after the strobe, captures per word
  always @(posedge ref_clk) begin
    if (rd_d) begin
      e = rq.pop_front();
      if (e[16]) cmp("reg_rdata", e[15:0], reg_rdata);
    end
    rd_d <= reg_rd;
    if (m_words != seen && cq.size() > 0) begin
      seen <= m_words;
      cmp("captured", cq.pop_front(), m_got & msk);
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares = miscompares + 1;
    end_of_test;
  end
  initial begin
    // width field never zero; all polarity and phase pairs
    cfgs[0] = 16'h4017;
    cfgs[1] = 16'h402f;
    cfgs[2] = 16'h4051;
    cfgs[3] = 16'h4564;
    rlds[0] = 16'h0003;
    rlds[1] = 16'h0004;
    rlds[2] = 16'h0003;
    rlds[3] = 16'h0005;
    tmp = $urandom(32'h5011);
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(`SSP_ADDR_CTRL, 16'h0000, 1'b1);
    rd(`SSP_ADDR_BAUD, 16'h0000, 1'b1);
    rd(`SSP_ADDR_IRQ_CLR, 16'h0000, 1'b1);
    rd(16'hffb0, 16'h0000, 1'b1);
    for (c = 0; c < 4; c = c + 1) begin
      cf = cfgs[c];
      nbits = cf[3:0] + 5'd1;
      msk = 16'hffff >> (15 - cf[3:0]);
      clr <= 1'b1;
      pol_t <= cf[`SSP_B_POL];
      pha_t <= cf[`SSP_B_PHASE];
      wr(`SSP_ADDR_CTRL, cf);
      rd(`SSP_ADDR_CTRL, cf, 1'b1);
      wr(`SSP_ADDR_BAUD, rlds[c]);
      rd(`SSP_ADDR_BAUD, rlds[c], 1'b1);
      wr(`SSP_ADDR_IRQ_EN, 16'h0001);
      rd(`SSP_ADDR_IRQ_EN, 16'h0001, 1'b1);
      wr(`SSP_ADDR_CTRL, cf | 16'h8000);
      rd(`SSP_ADDR_CTRL, 16'h0000, 1'b0);
      clr <= 1'b0;
      // refill while the shifter is busy, on each buffer-moved event
      for (i = 0; i < 3; i = i + 1) begin
        ws[i] = $urandom & msk;
        wr(`SSP_ADDR_TXBUF, ws[i]);
        cq.push_back(bits_of(ws[i], nbits, cf[`SSP_B_ORDER]));
        k = 0;
        while (irq !== 1'b1 && k < 400) settle;
        cmp("irq", 16'h0001, {15'h0000, irq});
        wr(`SSP_ADDR_IRQ_CLR, 16'h0001);
      end
      k = 0;
      while (cq.size() != 0 && k < 1000) settle;
      repeat (6) @(posedge ref_clk);
      // the chain returns the word before, so duplex data shows here
      rd(`SSP_ADDR_RXBUF, ws[1], 1'b1);
      rd(`SSP_ADDR_IRQ_STAT, 16'h0006, 1'b1);
      settle;
      cmp("irq", 16'h0000, {15'h0000, irq});
      wr(`SSP_ADDR_CTRL, cf);
      wr(`SSP_ADDR_IRQ_CLR, 16'h000f);
      rd(`SSP_ADDR_IRQ_STAT, 16'h0000, 1'b1);
    end
    // slave: a leading pin edge with nothing loaded is a transmit error
    clr <= 1'b1;
    pol_t <= 1'b0;
    wr(`SSP_ADDR_CTRL, 16'h0107);
    wr(`SSP_ADDR_CTRL, 16'h8107);
    pol_t <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(`SSP_ADDR_CTRL, 16'h9100, 1'b1);
    rd(`SSP_ADDR_IRQ_STAT, 16'h0008, 1'b1);
    repeat (4) @(posedge ref_clk);
    end_of_test;
  end
endmodule // tb_ssp_core
